// >>> buf_pkg.sv
package buf_pkg;
  // ----------------------------------------
  // buffer geometry and register map
  // ----------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int REG_W = 3;
  localparam int HIGH_BITS = ADDR_W - DATA_W;
  localparam logic [REG_W-1:0] OFS_CMD = 3'h1;
  localparam logic [REG_W-1:0] OFS_PTR_HIGH = 3'h2;
  localparam logic [REG_W-1:0] OFS_PTR_LOW = 3'h3;
  localparam logic [REG_W-1:0] OFS_DATA = 3'h4;
  localparam logic [REG_W-1:0] OFS_SETUP = 3'h7;
  localparam int AUTOINC_BIT = 7;
  localparam int HALF_RATE_BIT = 0;
  localparam int OFFSET_FLAG_BIT = 5;
  localparam int PAGE_LSB = 3;
  localparam logic [2:0] CMD_OP_TX = 3'h3;
  localparam logic [2:0] CMD_OP_RX = 3'h4;
  localparam int PAGE_BYTES = 512;
  localparam int HALF_PAGE_BYTES = 256;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_CYCLE_NS = 40;
  localparam int ACCESS_GAP_CYCLES = (ACCESS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // host apb map
  // ----------------------------------------
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_ADDR = 12'h004;
  localparam logic [11:0] APB_WDATA = 12'h008;
  localparam logic [11:0] APB_STATUS = 12'h00C;
  localparam int CTRL_REG_LSB = 4;
  localparam int ADDR_AUTOINC_BIT = 16;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ERR_BIT = 1;
  localparam int STATUS_RDATA_LSB = 8;
  typedef enum logic [2:0] {
    OP_LOAD = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_REG_RD = 3'b011,
    OP_REG_WR = 3'b100
  } host_op_type;
  // ----------------------------------------
  // shared arithmetic
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] page_start(input logic [1:0] page_number_field,
                                                   input logic f);
    return ADDR_W'(int'(page_number_field) * PAGE_BYTES + int'(f) * HALF_PAGE_BYTES);
  endfunction
  function automatic logic [DATA_W-1:0] high_byte(input logic [ADDR_W-1:0] a,
                                                  input logic inc);
    logic [DATA_W-1:0] b;
    b = '0;
    b[HIGH_BITS-1:0] = a[ADDR_W-1:DATA_W];
    b[AUTOINC_BIT] = inc;
    return b;
  endfunction
endpackage

// >>> buf_port_if.sv
`timescale 1ns/10ps
interface buf_port_if;
  logic cs;
  logic wr;
  logic [buf_pkg::REG_W-1:0] addr;
  logic [buf_pkg::DATA_W-1:0] wdata;
  logic [buf_pkg::DATA_W-1:0] rdata;
  modport host (
    output cs,
    output wr,
    output addr,
    output wdata,
    input rdata
  );
  modport device (
    input cs,
    input wr,
    input addr,
    input wdata,
    output rdata
  );
endinterface

// >>> two_entry_buffer.sv
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_idx;
  logic [PW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] i);
    return (i == PW'(DEPTH - 1)) ? '0 : PW'(i + 1'b1);
  endfunction

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = store[rd_idx];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      store[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_idx <= bump(wr_idx);
      if (pop) rd_idx <= bump(rd_idx);
      count <= next_count;
      in_ready <= (next_count != CW'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end
endmodule

// >>> buf_ram_device.sv
// Summary of operation
// R1 - pointer high at 02H, low at 03H
// R2 - host data bytes pass through 04H data port; receive bytes go to RAM directly
// R3 - low pointer write commits; high first
// R4 - commit prefetches addressed byte into data
// R5 - auto-increment advances pointer, prefetches next
// R6 - host reloads pointer on direction change
// R7 - host waits access cycle before read
// R8 - data writes staged, RAM written later
// R9 - setup bit 0 halves arbitration rate
// R10 - pointer reads return current address
// R11 - host writes high, then low, then data
// R12 - RAM is four 512-byte pages
// R13 - offset flag bit 5 adds 256
// R14 - 0010 0011 transmits from page 0 upper half
// R15 - start = page times 512 plus flag times 256
// R16 - receive writes sequentially, no boundary check
// R17 - software reserves 512 bytes per receive page
// R18 - pointer wraps modulo 2048
`timescale 1ns/10ps
module buf_ram_device #(
  parameter int RAM_DEPTH = 2048,
  parameter int RX_DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  buf_port_if.device bus,
  input wire logic rx_valid,
  input wire logic [buf_pkg::DATA_W-1:0] rx_data,
  output logic rx_ready,
  output logic [buf_pkg::ADDR_W-1:0] tx_page_start,
  output logic [buf_pkg::ADDR_W-1:0] rx_page_start,
  output logic [buf_pkg::ADDR_W-1:0] rx_write_ptr
);
  import buf_pkg::*;

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [DATA_W-1:0] mem [RAM_DEPTH];
  logic [ADDR_W-1:0] ptr;
  logic [HIGH_BITS-1:0] ptr_high;
  logic auto_inc;
  logic [DATA_W-1:0] data_hold;
  logic [DATA_W-1:0] temp_byte;
  logic write_pend;
  logic prefetch_pend;
  logic half_rate_arbitration;
  logic arb_phase;
  logic arb_go;
  logic host_wr;
  logic host_rd;
  logic ram_store;
  logic ram_fetch;
  logic rx_take;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign host_wr = bus.cs & bus.wr;
  assign host_rd = bus.cs & ~bus.wr;
  assign arb_go = ~half_rate_arbitration | arb_phase; // [R9]
  assign ram_store = arb_go & write_pend;
  assign ram_fetch = arb_go & ~write_pend & prefetch_pend;
  assign rx_take = arb_go & ~write_pend & ~prefetch_pend & fifo_valid;

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  two_entry_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(RX_DEPTH)
  ) rx_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(rx_take)
  );

  // ----------------------------------------
  // setup and arbitration clocking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_rate_arbitration <= 1'b0;
    end else if (host_wr && bus.addr == OFS_SETUP) begin
      half_rate_arbitration <= bus.wdata[HALF_RATE_BIT]; // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_phase <= 1'b0;
    end else begin
      arb_phase <= ~arb_phase; // [R9]
    end
  end

  // ----------------------------------------
  // pointer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_high <= '0;
      auto_inc <= 1'b0;
    end else if (host_wr && bus.addr == OFS_PTR_HIGH) begin
      ptr_high <= bus.wdata[HIGH_BITS-1:0]; // [R1]
      auto_inc <= bus.wdata[AUTOINC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
    end else if (host_wr && bus.addr == OFS_PTR_LOW) begin
      ptr <= {ptr_high, bus.wdata}; // [R1] [R3]
    end else if (host_rd && bus.addr == OFS_DATA && auto_inc) begin
      ptr <= ADDR_W'(ptr + 1'b1); // [R5] [R18]
    end else if (ram_store && auto_inc) begin
      ptr <= ADDR_W'(ptr + 1'b1); // [R5] [R18]
    end
  end

  // ----------------------------------------
  // prefetch and staged write
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_pend <= 1'b0;
    end else if (host_wr && bus.addr == OFS_PTR_LOW) begin
      prefetch_pend <= 1'b1; // [R4]
    end else if (host_rd && bus.addr == OFS_DATA && auto_inc) begin
      prefetch_pend <= 1'b1; // [R5]
    end else if (ram_fetch) begin
      prefetch_pend <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_byte <= '0;
      write_pend <= 1'b0;
    end else if (host_wr && bus.addr == OFS_DATA) begin
      temp_byte <= bus.wdata; // [R2] [R8]
      write_pend <= 1'b1; // [R8]
    end else if (ram_store) begin
      write_pend <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_hold <= '0;
    end else if (ram_fetch) begin
      data_hold <= mem[ptr]; // [R4] [R5]
    end
  end

  // ----------------------------------------
  // ram write port
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (ram_store) begin
      mem[ptr] <= temp_byte; // [R8]
    end else if (rx_take) begin
      mem[rx_write_ptr] <= fifo_data; // [R16]
    end
  end

  // ----------------------------------------
  // page commands and receive pointer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_page_start <= '0;
      rx_page_start <= '0;
    end else if (host_wr && bus.addr == OFS_CMD) begin
      if (bus.wdata[2:0] == CMD_OP_TX) begin
        // [R12] [R13] [R14] [R15]
        tx_page_start <= page_start(bus.wdata[PAGE_LSB +: 2], bus.wdata[OFFSET_FLAG_BIT]);
      end else if (bus.wdata[2:0] == CMD_OP_RX) begin
        // [R12] [R13] [R15]
        rx_page_start <= page_start(bus.wdata[PAGE_LSB +: 2], bus.wdata[OFFSET_FLAG_BIT]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_write_ptr <= '0;
    end else if (host_wr && bus.addr == OFS_CMD && bus.wdata[2:0] == CMD_OP_RX) begin
      rx_write_ptr <= page_start(bus.wdata[PAGE_LSB +: 2], bus.wdata[OFFSET_FLAG_BIT]);
    end else if (rx_take) begin
      rx_write_ptr <= ADDR_W'(rx_write_ptr + 1'b1); // [R16] [R18]
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.rdata <= '0;
    end else if (host_rd) begin
      unique case (bus.addr)
        OFS_PTR_HIGH: begin
          bus.rdata <= high_byte(ptr, auto_inc); // [R10]
        end
        OFS_PTR_LOW: begin
          bus.rdata <= ptr[DATA_W-1:0]; // [R10]
        end
        OFS_DATA: begin
          bus.rdata <= data_hold; // [R2] [R4]
        end
        OFS_SETUP: begin
          bus.rdata <= DATA_W'(half_rate_arbitration);
        end
        default: begin
          bus.rdata <= '0;
        end
      endcase
    end
  end
endmodule

// >>> buf_ram_host.sv
`timescale 1ns/10ps
module buf_ram_host #(
  parameter int GAP_CYCLES = buf_pkg::ACCESS_GAP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  buf_port_if.host bus
);
  import buf_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HIGH = 3'b001,
    ST_LOW = 3'b010,
    ST_DATA = 3'b011,
    ST_CAPTURE = 3'b100,
    ST_GAP = 3'b101
  } state_type;

  state_type state;
  host_op_type op;
  logic [ADDR_W-1:0] start_addr;
  logic auto_inc;
  logic [DATA_W-1:0] out_byte;
  logic [DATA_W-1:0] in_byte;
  logic [REG_W-1:0] reg_sel;
  logic err;
  logic dir_known;
  logic last_dir_wr;
  logic [7:0] gap_cnt;
  logic setup_ph;
  logic access;
  logic go;
  logic dir_clash;
  logic op_wr;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup_ph = psel & ~penable;
  assign access = psel & penable & pready;
  assign go = access & pwrite & (paddr == APB_CTRL) & (state == ST_IDLE);
  assign op_wr = (pwdata[2:0] == OP_WRITE);
  assign dir_clash = dir_known & (last_dir_wr != op_wr) &
                     ((pwdata[2:0] == OP_READ) | op_wr); // [R6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & (paddr != APB_CTRL) & (paddr != APB_ADDR) &
                 (paddr != APB_WDATA) & (paddr != APB_STATUS);
      if (setup_ph) begin
        prdata <= '0;
        if (paddr == APB_ADDR) begin
          prdata <= {15'h0000, auto_inc, 5'h00, start_addr};
        end else if (paddr == APB_WDATA) begin
          prdata <= {24'h000000, out_byte};
        end else if (paddr == APB_STATUS) begin
          prdata <= {16'h0000, in_byte, 6'h00, err, state != ST_IDLE};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_addr <= '0;
      auto_inc <= 1'b0;
      out_byte <= '0;
    end else if (access && pwrite) begin
      if (paddr == APB_ADDR) begin
        start_addr <= pwdata[ADDR_W-1:0];
        auto_inc <= pwdata[ADDR_AUTOINC_BIT];
      end else if (paddr == APB_WDATA) begin
        out_byte <= pwdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
    end else if (go && dir_clash) begin
      err <= 1'b1; // [R6]
    end else if (access && pwrite && paddr == APB_STATUS && pwdata[STATUS_ERR_BIT]) begin
      err <= 1'b0;
    end
  end

  // ----------------------------------------
  // direction tracking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_known <= 1'b0;
      last_dir_wr <= 1'b0;
    end else if (state == ST_LOW) begin
      dir_known <= 1'b0; // [R6]
    end else if (state == ST_DATA && (op == OP_READ || op == OP_WRITE)) begin
      dir_known <= 1'b1;
      last_dir_wr <= (op == OP_WRITE);
    end
  end

  // ----------------------------------------
  // device bus sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= OP_LOAD;
      reg_sel <= '0;
      gap_cnt <= '0;
      in_byte <= '0;
      bus.cs <= 1'b0;
      bus.wr <= 1'b0;
      bus.addr <= '0;
      bus.wdata <= '0;
    end else begin
      bus.cs <= 1'b0;
      bus.wr <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (go && !dir_clash) begin
            op <= host_op_type'(pwdata[2:0]);
            reg_sel <= pwdata[CTRL_REG_LSB +: REG_W];
            bus.cs <= 1'b1;
            if (pwdata[2:0] == OP_LOAD) begin
              state <= ST_HIGH;
              bus.wr <= 1'b1;
              bus.addr <= OFS_PTR_HIGH; // [R3] [R11]
              bus.wdata <= high_byte(start_addr, auto_inc);
            end else begin
              state <= ST_DATA;
              bus.wr <= op_wr | (pwdata[2:0] == OP_REG_WR);
              bus.addr <= (pwdata[2:0] == OP_READ || op_wr) ? OFS_DATA :
                          pwdata[CTRL_REG_LSB +: REG_W];
              bus.wdata <= out_byte;
            end
          end
        end
        ST_HIGH: begin
          state <= ST_LOW;
          bus.cs <= 1'b1;
          bus.wr <= 1'b1;
          bus.addr <= OFS_PTR_LOW; // [R3] [R11]
          bus.wdata <= start_addr[DATA_W-1:0];
        end
        ST_LOW: begin
          state <= ST_GAP;
          gap_cnt <= 8'(GAP_CYCLES); // [R7]
        end
        ST_DATA: begin
          state <= (op == OP_READ || op == OP_REG_RD) ? ST_CAPTURE : ST_GAP;
          gap_cnt <= 8'(GAP_CYCLES);
        end
        ST_CAPTURE: begin
          in_byte <= bus.rdata;
          state <= ST_GAP;
        end
        ST_GAP: begin
          if (gap_cnt <= 8'h01) begin
            state <= ST_IDLE; // [R7]
          end else begin
            gap_cnt <= 8'(gap_cnt - 1'b1);
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> sequential_buffer_ram_access_monitor.sv
`timescale 1ns/10ps
module sequential_buffer_ram_access_monitor
  import buf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs,
  input wire logic wr,
  input wire logic [buf_pkg::REG_W-1:0] addr,
  input wire logic [buf_pkg::DATA_W-1:0] wdata,
  input wire logic [buf_pkg::DATA_W-1:0] rdata
);
  // ----------------------------------------
  // port bus checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire hi_wr = cs && wr && addr == OFS_PTR_HIGH;
  wire lo_wr = cs && wr && addr == OFS_PTR_LOW;
  a_high_then_low: assert property (hi_wr |=> lo_wr)
    else $error("high pointer write not followed by low write");
  a_low_after_high: assert property (lo_wr |-> $past(hi_wr))
    else $error("low pointer write without high write before it");
  a_load_gap_kept: assert property (lo_wr |=> !cs [*4])
    else $error("access too soon after pointer commit");
  a_op_gap_kept: assert property (cs && !hi_wr && !lo_wr |=> !cs [*4])
    else $error("access too soon after data or register op");
  a_rdata_holds: assert property (!(cs && !wr) |=> $stable(rdata))
    else $error("read data changed without a read");
  a_offset_legal: assert property (cs |-> addr inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7})
    else $error("access to an unused offset");
  a_high_byte_pad: assert property (hi_wr |-> wdata[6:3] == 4'h0)
    else $error("high pointer byte has stray bits");
  a_idle_before_load: assert property (hi_wr |-> !$past(cs))
    else $error("pointer load starts right after another access");
  c_load: cover property (lo_wr);
  c_data_read: cover property (cs && !wr && addr == OFS_DATA);
  c_data_write: cover property (cs && wr && addr == OFS_DATA);
  c_cmd_write: cover property (cs && wr && addr == OFS_CMD);
endmodule

// >>> sequential_buffer_ram_access_bench.sv
`timescale 1ns/10ps
module sequential_buffer_ram_access_bench;
  import buf_pkg::*;
  logic pclk = 0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ready, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [7:0] rx_data;
  logic [ADDR_W-1:0] tx_page_start, rx_page_start, rx_write_ptr;
  logic [7:0] mem [2048];
  int ptr, inc, failures = 0, cmp_count = 0, cycles = 0;
  // ----------------------------------------
  // design ends
  // ----------------------------------------
  buf_port_if link ();
  buf_ram_host i_buf_ram_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));
  buf_ram_device i_buf_ram_device (.pclk(pclk), .presetn(presetn), .bus(link),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_page_start(tx_page_start), .rx_page_start(rx_page_start),
    .rx_write_ptr(rx_write_ptr));
  sequential_buffer_ram_access_monitor i_mon (.pclk(pclk), .presetn(presetn),
    .cs(link.cs), .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));
  always #5 pclk = ~pclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    st = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(input host_op_type c, input logic [2:0] ro, input logic [7:0] d);
    apb(1'b1, APB_WDATA, {24'h0, d});
    apb(1'b1, APB_CTRL, {25'h0, ro, 1'b0, c});
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
    end while (st[STATUS_BUSY_BIT] !== 1'b0);
  endtask
  task automatic load(input int a, input int i);
    apb(1'b1, APB_ADDR, 32'(a | (i << ADDR_AUTOINC_BIT)));
    op(OP_LOAD, 3'h0, 8'h00);
    ptr = a;
    inc = i;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    op(OP_WRITE, 3'h0, d);
    mem[ptr] = d;
    ptr = (ptr + inc) % 2048;
  endtask
  task automatic rd_byte();
    op(OP_READ, 3'h0, 8'h00);
    chk("read byte", {24'h0, mem[ptr]}, {24'h0, st[15:8]});
    ptr = (ptr + inc) % 2048;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] b, cv;
    int n, e;
    {psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data, presetn} = '0;
    void'($urandom(62490));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h010, 32'h0);
    chk("slverr", 1, slv);
    load(2040, 1);
    for (int i = 0; i < 16; i++) wr_byte(8'($urandom));
    op(OP_READ, 3'h0, 8'h00);
    chk("dir error", 1, st[STATUS_ERR_BIT]);
    apb(1'b1, APB_STATUS, 32'h2);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("error clear", 0, st[STATUS_ERR_BIT]);
    load(2040, 1);
    for (int i = 0; i < 16; i++) rd_byte();
    op(OP_REG_RD, OFS_PTR_LOW, 8'h00);
    chk("ptr low", ptr & 255, st[15:8]);
    op(OP_REG_RD, OFS_PTR_HIGH, 8'h00);
    chk("ptr high", ptr >> 8, st[10:8]);
    load(100, 0);
    wr_byte(8'($urandom));
    load(100, 0);
    rd_byte();
    rd_byte();
    for (int o = 0; o < 2; o++) begin
      for (int p = 0; p < 8; p++) begin
        cv = 8'(((p >> 2) << OFFSET_FLAG_BIT) | ((p & 3) << PAGE_LSB)) | {5'h0, o ? CMD_OP_RX : CMD_OP_TX};
        op(OP_REG_WR, OFS_CMD, cv);
        e = (p & 3) * 512 + (p >> 2) * 256;
        chk("page start", e, o ? rx_page_start : tx_page_start);
      end
    end
    op(OP_REG_WR, OFS_SETUP, 8'h01);
    op(OP_REG_WR, OFS_CMD, 8'h3C);
    chk("rx ptr", 1792, rx_write_ptr);
    rx_valid <= 1'b1;
    for (int i = 0; i < 300; i++) begin // stream runs past 2047 and wraps into page 0
      b = 8'($urandom);
      mem[(1792 + i) % 2048] = b;
      rx_data <= b;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rx_ready !== 1'b1 && n < 100);
    end
    rx_valid <= 1'b0;
    n = 0;
    while (rx_write_ptr !== 11'((1792 + 300) % 2048) && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("rx end", (1792 + 300) % 2048, rx_write_ptr);
    load(1792, 1);
    for (int i = 0; i < 300; i++) rd_byte();
    give_verdict();
  end
endmodule
